// ===== logic/pin_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
// Assumes the caller reads only q.
`default_nettype none

module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync

`default_nettype wire

// ===== logic/serial_device_end.sv
// Device end of the serial register port with its byte register file.
// Assumes the host keeps sclk well below clk/6 and select low per access.
//
// How it works
// - Host holds select low for whole access
// - Sample serial input on rising serial clock
// - No lower clock limit, no timeout
// - Frame is 24 bits, plus eight per streamed byte
// - First bit one reads, zero writes
// - Next 15 bits are register address
// - Write stores last eight input bits
// - Read ignores input, drives register out
// - All fields most significant bit first
// - Wide registers little-endian across addresses
// - Output released except read data bits
// - Held select streams further bytes
// - Address steps by one per byte
// - Register zero bit five picks direction
// - Reserved bits read their reset value
`default_nettype none

module serial_device_end
  import serial_port_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
)
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  serial_link_if.device                link,
  output logic                         reg_wr_valid,
  output logic [ADDR_W-1:0]            reg_wr_addr,
  output logic [DATA_W-1:0]            reg_wr_data,
  output logic                         stream_addr_up,
  output logic [8*WIDE_BYTES-1:0]      wide_value
);
  localparam int IDX_W = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic              sclk_q;
  logic              sel_n_q;
  logic              sdi_q;
  logic              sclk_prev;
  logic              rise;
  logic              fall;
  logic [3:0]        hdr_cnt;
  logic [14:0]       hdr;
  logic              in_data;
  logic              is_read;
  logic [ADDR_W-1:0] addr;
  logic [2:0]        dcnt;
  logic [6:0]        data_sh;
  logic [7:0]        out_sh;
  logic [ADDR_W-1:0] hdr_addr;
  logic              hdr_done;
  logic              byte_done;

  pin_sync #(.WIDTH(3)) u_sync
  (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .d      ({link.sclk, link.serial_select_n, link.sdi}),
    .q      ({sclk_q, sel_n_q, sdi_q})
  );

  // Step to the next streaming address
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
    if (mem[CFG_ADDR[IDX_W-1:0]][STREAM_UP_BIT])
      step_addr = a + 15'h0001;
    else
      step_addr = a - 15'h0001;
  endfunction : step_addr

  // Byte returned for an address; unmapped reads give zero
  function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
    if (a >= ADDR_W'(DEPTH))
      read_byte = 8'h00;
    else if (a == CFG_ADDR)
      read_byte = (mem[a[IDX_W-1:0]] & CFG_WR_MASK) | (CFG_RESET & ~CFG_WR_MASK);
    else
      read_byte = mem[a[IDX_W-1:0]];
  endfunction : read_byte

  // Edges count only while selected
  assign rise      = sclk_q & ~sclk_prev & ~sel_n_q;
  assign fall      = ~sclk_q & sclk_prev & ~sel_n_q;
  assign hdr_addr  = {hdr[13:0], sdi_q};
  assign hdr_done  = rise & ~in_data & (hdr_cnt == 4'(HDR_BITS - 1));
  assign byte_done = rise & in_data & (dcnt == 3'h7);

  always_ff @(posedge clk)
  begin
    if (reset)
      sclk_prev <= 1'b0;
    else if (clk_en)
      sclk_prev <= sclk_q;
  end

  // Frame sequencing: header, then bytes while select stays low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hdr_cnt <= 4'h0;
      hdr     <= 15'h0000;
      in_data <= 1'b0;
      is_read <= 1'b0;
      addr    <= '0;
      dcnt    <= 3'h0;
      data_sh <= 7'h00;
    end
    else if (clk_en)
    begin
      if (sel_n_q)
      begin
        hdr_cnt <= 4'h0;
        in_data <= 1'b0;
        dcnt    <= 3'h0;
      end
      else if (hdr_done)
      begin
        in_data <= 1'b1;
        is_read <= hdr[14];
        addr    <= hdr_addr;
        dcnt    <= 3'h0;
      end
      else if (rise && !in_data)
      begin
        hdr     <= {hdr[13:0], sdi_q};
        hdr_cnt <= hdr_cnt + 4'h1;
      end
      else if (rise)
      begin
        data_sh <= {data_sh[5:0], sdi_q};
        dcnt    <= dcnt + 3'h1;
        if (dcnt == 3'h7)
          addr <= step_addr(addr);
      end
    end
  end

  // Register file; writes land on the eighth data bit
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= (i == int'(CFG_ADDR)) ? CFG_RESET : REG_RESET;
      reg_wr_valid <= 1'b0;
      reg_wr_addr  <= '0;
      reg_wr_data  <= 8'h00;
    end
    else if (clk_en)
    begin
      reg_wr_valid <= 1'b0;
      if (byte_done && !is_read)
      begin
        reg_wr_valid <= 1'b1;
        reg_wr_addr  <= addr;
        reg_wr_data  <= {data_sh, sdi_q};
        if (addr == CFG_ADDR)
          mem[addr[IDX_W-1:0]] <= {data_sh, sdi_q} & CFG_WR_MASK;
        else if (addr < ADDR_W'(DEPTH))
          mem[addr[IDX_W-1:0]] <= {data_sh, sdi_q};
      end
    end
  end

  // Serial output: driven only during read data bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      link.sdo_oe  <= 1'b0;
      link.sdo_out <= 1'b0;
      out_sh       <= 8'h00;
    end
    else if (clk_en)
    begin
      if (sel_n_q)
      begin
        link.sdo_oe  <= 1'b0;
        link.sdo_out <= 1'b0;
      end
      else if (hdr_done && hdr[14])
      begin
        out_sh       <= read_byte(hdr_addr);
        link.sdo_out <= 1'(read_byte(hdr_addr) >> 7);
        link.sdo_oe  <= 1'b1;
      end
      else if (byte_done && is_read)
      begin
        out_sh       <= read_byte(step_addr(addr));
        link.sdo_out <= 1'(read_byte(step_addr(addr)) >> 7);
      end
      else if (fall && in_data && is_read && dcnt != 3'h0)
        link.sdo_out <= out_sh[3'h7 - dcnt];
    end
  end

  assign stream_addr_up = mem[CFG_ADDR[IDX_W-1:0]][STREAM_UP_BIT];

  // Multi-byte view: lowest address is least significant byte
  generate
    for (genvar k = 0; k < WIDE_BYTES; k++)
    begin : g_wide
      assign wide_value[8*k +: 8] = mem[WIDE_BASE + k];
    end
  endgenerate
endmodule : serial_device_end

`default_nettype wire

// ===== logic/serial_host_end.sv
// Host end: issues single and streaming accesses on the serial link.
// Assumes the user supplies next write byte before each byte boundary.
`default_nettype none

module serial_host_end
  import serial_port_pkg::*;
#(
  parameter int HALF_DIV = SCLK_HALF_DIV
)
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  serial_link_if.host             link,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               req_read,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [COUNT_W-1:0] req_count,
  input  wire logic [DATA_W-1:0]  wr_byte,
  output logic                    wr_take,
  output logic [DATA_W-1:0]       rd_byte,
  output logic                    rd_valid,
  output logic                    done
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} host_state_e;

  host_state_e        state;
  logic [DIV_W-1:0]   div;
  logic [23:0]        shift;
  logic [4:0]         bits_left;
  logic [COUNT_W-1:0] bytes_left;
  logic               is_read;
  logic [7:0]         rx;
  logic               sdo_q;
  logic               div_end;

  pin_sync #(.WIDTH(1)) u_sync
  (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .d      (link.sdo),
    .q      (sdo_q)
  );

  assign div_end = (div == DIV_W'(HALF_DIV - 1));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state                <= H_IDLE;
      div                  <= '0;
      shift                <= 24'h000000;
      bits_left            <= 5'h00;
      bytes_left           <= '0;
      is_read              <= 1'b0;
      rx                   <= 8'h00;
      req_ready            <= 1'b0;
      wr_take              <= 1'b0;
      rd_byte              <= 8'h00;
      rd_valid             <= 1'b0;
      done                 <= 1'b0;
      link.sclk            <= 1'b0;
      link.serial_select_n <= 1'b1;
      link.sdi             <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      div      <= div_end ? '0 : div + DIV_W'(1);
      unique case (state)
        H_IDLE:
        begin
          div       <= '0;
          req_ready <= 1'b1;
          if (req_valid && req_ready)
          begin
            req_ready            <= 1'b0;
            is_read              <= req_read;
            shift                <= {req_read, req_addr, wr_byte};
            wr_take              <= ~req_read;
            bits_left            <= 5'(FRAME_BITS);
            bytes_left           <= req_count;
            link.serial_select_n <= 1'b0;
            link.sdi             <= req_read;
            state                <= H_LOW;
          end
        end
        H_LOW:
        begin
          if (div_end)
          begin
            link.sclk <= 1'b1;
            rx        <= {rx[6:0], sdo_q};
            state     <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          if (div_end)
          begin
            link.sclk <= 1'b0;
            bits_left <= bits_left - 5'h01;
            state     <= H_LOW;
            if (bits_left == 5'h01)
            begin
              rd_byte  <= rx;
              rd_valid <= is_read;
              if (bytes_left != '0)
              begin
                bytes_left <= bytes_left - COUNT_W'(1);
                bits_left  <= 5'(DATA_W);
                shift      <= {wr_byte, 16'h0000};
                wr_take    <= ~is_read;
                link.sdi   <= is_read ? 1'b0 : wr_byte[7];
              end
              else
                state <= H_END;
            end
            else
            begin
              shift    <= {shift[22:0], 1'b0};
              link.sdi <= shift[22];
            end
          end
        end
        H_END:
        begin
          if (div_end)
          begin
            link.serial_select_n <= 1'b1;
            link.sdi             <= 1'b0;
            done                 <= 1'b1;
            state                <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : serial_host_end

`default_nettype wire

// ===== logic/serial_link_if.sv
// Four-wire serial link between host and device.
// The shared data-out wire is resolved here from the device enable.
`default_nettype none

interface serial_link_if;
  logic sclk;
  logic serial_select_n;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  wire  sdo;

  // Released line reads as its pull-up level
  assign sdo = sdo_oe ? sdo_out : 1'b1;

  modport device
  (
    input  sclk,
    input  serial_select_n,
    input  sdi,
    output sdo_out,
    output sdo_oe
  );

  modport host
  (
    output sclk,
    output serial_select_n,
    output sdi,
    input  sdo
  );
endinterface : serial_link_if

`default_nettype wire

// ===== logic/serial_port_pkg.sv
// Shared constants for the serial register port, both ends.
// Assumes both ends run on one 25 MHz system clock.
`default_nettype none

package serial_port_pkg;
  localparam int          FRAME_BITS     = 24;
  localparam int          ADDR_W         = 15;
  localparam int          DATA_W         = 8;
  localparam int          HDR_BITS       = 1 + ADDR_W;
  localparam logic [14:0] CFG_ADDR       = 15'h0000;
  localparam int          STREAM_UP_BIT  = 5;
  localparam logic [7:0]  CFG_RESET      = 8'h20;
  localparam logic [7:0]  CFG_WR_MASK    = 8'h20;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          REG_DEPTH      = 64;
  localparam int          SCLK_HALF_DIV  = 8;
  localparam int          DIV_W          = 8;
  localparam int          COUNT_W        = 8;
  localparam int          WIDE_BASE      = 1;
  localparam int          WIDE_BYTES     = 2;
endpackage : serial_port_pkg

`default_nettype wire

// ===== test/serial_register_port_assertions.sv
// Concurrent checks on the serial link joining host and device ends.
// Assumes a host half period of 6 clk and clk_en held high.
`default_nettype none

module serial_register_port_assertions
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        prev;
  logic        rd;
  logic [15:0] rises;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  always_ff @(posedge clk)
  begin
    prev <= reset ? 1'b0 : sclk;
  end

  // Rising serial clock edges within the current frame
  always_ff @(posedge clk)
  begin
    if (reset || serial_select_n)
      rises <= 16'h0000;
    else if (sclk && !prev)
      rises <= rises + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rd <= 1'b0;
    else if (sclk && !prev && rises == 16'h0000)
      rd <= sdi;
  end

  sequence high_run;
    sclk [*6];
  endsequence

  sequence low_run;
    !sclk [*6];
  endsequence

  AST_SCLK_IDLE: assert property (serial_select_n |-> !sclk)
    else $error("sclk active while deselected");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> high_run)
    else $error("sclk high phase short");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> low_run)
    else $error("sclk low phase short");
  AST_SDI_HELD: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("sdi moved while sclk high");
  AST_WRITE_QUIET: assert property (!rd && rises != 16'h0000 |-> !sdo_oe)
    else $error("sdo driven in write frame");
  AST_OE_AFTER_HDR: assert property ($rose(sdo_oe) |-> rd && rises == 16'h0010)
    else $error("sdo enabled off header end");
  AST_SDO_STEADY: assert property (sdo_oe && sclk && $past(sclk) && rises[2:0] != 3'h0
    |-> $stable(sdo_out))
    else $error("sdo moved while sclk high");
  AST_SDO_RELEASE: assert property ($rose(serial_select_n) |-> ##[1:5] !sdo_oe)
    else $error("sdo not released");
  AST_FRAME_BITS: assert property ($rose(serial_select_n)
    |-> rises >= 16'h0018 && rises[2:0] == 3'h0)
    else $error("frame not whole bytes");
endmodule : serial_register_port_assertions

`default_nettype wire

// ===== test/serial_register_port_tb_top.sv
// Bench joining host and device ends through one serial link.
// Assumes the host user port is the only stimulus; clk_en tied high.
`default_nettype none

module serial_register_port_tb_top
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 6;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic               req_valid = 1'b0;
  logic               req_read = 1'b0;
  logic [ADDR_W-1:0]  req_addr = 15'h0000;
  logic [COUNT_W-1:0] req_count = 8'h00;
  logic [DATA_W-1:0]  wr_byte = 8'h00;
  logic               req_ready, wr_take, rd_valid, done;
  logic               reg_wr_valid, stream_addr_up;
  logic [DATA_W-1:0]  rd_byte, reg_wr_data, last_data;
  logic [ADDR_W-1:0]  reg_wr_addr, last_addr;
  logic [15:0]        wide_value;
  logic [15:0]        wr_n = 16'h0000;
  logic [7:0]         wbuf [8];
  logic [15:0]        rbuf [8];
  int                 err_total = 0;
  int                 check_count = 0;

  serial_link_if link ();

  serial_host_end #(.HALF_DIV(HALF)) serial_host_end_inst
  (
    .clk(clk), .reset(reset), .clk_en(1'b1), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
    .req_count(req_count), .wr_byte(wr_byte), .wr_take(wr_take), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .done(done)
  );

  serial_device_end serial_device_end_inst
  (
    .clk(clk), .reset(reset), .clk_en(1'b1), .link(link), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .stream_addr_up(stream_addr_up), .wide_value(wide_value)
  );

  serial_register_port_assertions serial_register_port_assertions_inst
  (
    .clk(clk), .reset(reset), .sclk(link.sclk), .serial_select_n(link.serial_select_n),
    .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe)
  );

  always #20 clk = ~clk;

  // Written bytes are taken mid-cycle, where the pulse has settled
  always @(negedge clk)
  begin
    if (reg_wr_valid === 1'b1)
    begin
      wr_n <= wr_n + 16'h0001;
      last_addr <= reg_wr_addr;
      last_data <= reg_wr_data;
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One host access; bytes to send come from wbuf, read bytes land in rbuf
  task automatic access(input logic rd, input logic [ADDR_W-1:0] a, input int extra);
    logic fin;
    logic rdy;
    int   w;
    int   k;
    fin = 1'b0;
    w = 0;
    k = 0;
    req_read = rd;
    req_addr = a;
    req_count = extra[COUNT_W-1:0];
    wr_byte = wbuf[0];
    req_valid = 1'b1;
    for (int i = 0; i < 2000 && !fin; i++)
    begin
      rdy = req_ready;
      @(posedge clk);
      #1;
      if (rdy === 1'b1)
        req_valid = 1'b0;
      if (wr_take === 1'b1)
      begin
        w++;
        wr_byte = wbuf[w % 8];
      end
      if (rd_valid === 1'b1)
      begin
        rbuf[k % 8] = {8'h00, rd_byte};
        k++;
      end
      if (done === 1'b1)
        fin = 1'b1;
    end
    check({15'h0000, fin}, 16'h0001);
  endtask : access

  initial
  begin
    for (int i = 0; i < 8; i++)
      wbuf[i] = 8'h11 * 8'(i + 1);
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, stream_addr_up}, 16'h0001);
    access(1'b1, 15'h0000, 0);
    check(rbuf[0], 16'h0020);
    access(1'b0, 15'h0001, 3);
    check(wr_n, 16'h0004);
    check({1'b0, last_addr}, 16'h0004);
    check(wide_value, 16'h2211);
    access(1'b1, 15'h0001, 3);
    for (int i = 0; i < 4; i++)
      check(rbuf[i], 16'(16'h0011 * (i + 1)));
    wbuf[0] = 8'h1E;
    access(1'b0, 15'h0005, 0);
    check({8'h00, last_data}, 16'h001E);
    check({1'b0, last_addr}, 16'h0005);
    access(1'b1, 15'h0005, 0);
    check(rbuf[0], 16'h001E);
    wbuf[0] = 8'hDF;
    access(1'b0, 15'h0000, 0);
    check({15'h0000, stream_addr_up}, 16'h0000);
    access(1'b1, 15'h0000, 0);
    check(rbuf[0], 16'h0000);
    access(1'b1, 15'h0004, 2);
    for (int i = 0; i < 3; i++)
      check(rbuf[i], 16'(16'h0011 * (4 - i)));
    access(1'b1, 15'h0100, 0);
    check(rbuf[0], 16'h0000);
    wrap_up();
  end

  initial
  begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule : serial_register_port_tb_top

`default_nettype wire
